// *** common/pmp_pkg.sv ***
// Package for the program-memory parity status block: offsets, fields, types.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package pmp_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 18;
    // Printed offsets step by one, not four: index, byte address = 4 * index
    localparam logic [15:0] PARITY_STATUS_IDX = 16'hF470;
    localparam logic [15:0] IRQ_STATUS_IDX = 16'hF471;
    localparam logic [15:0] IRQ_MASK_IDX = 16'hF472;
    localparam logic [ADDR_W-1:0] PARITY_STATUS_ADDR = {PARITY_STATUS_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int SUBBANKS = 6;
    localparam int BANK0_LSB = 0;
    localparam int BANK1_LSB = 8;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] FLAG_MASK = 16'h3F3F;
    localparam logic [15:0] MASK_RESET = 16'h0000;

    // Parity error strobes, one bit per subbank, from the memory read path
    typedef struct packed {
        logic [SUBBANKS-1:0] bank1;
        logic [SUBBANKS-1:0] bank0;
    } pmp_err_t;

    // Wishbone request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ADDR_W-1:0] adr;
        logic [31:0] dat;
    } pmp_wb_req_t;

endpackage : pmp_pkg

// *** hdl/pmp_parity_status.sv ***
// Program-memory parity status register with a Wishbone slave and interrupt.
// Assumes error strobes come from logic on core_clk, one cycle per failed read.
// Function
// RULE1: Bit 13 flags bank 1 subbank 5 error
// RULE2: Bank 1 subbanks 4..0 on bits 12..8
// RULE3: Bank 0 subbanks 5..0 on bits 5..0
// RULE4: Flag 1 means error; read-only
// RULE5: Register at 0xF470, resets to all zero
// RULE6: Flag sticky until reset; reserved read zero
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
module pmp_parity_status
    import pmp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Parity check results
    input wire pmp_err_t parityErr,
    // Wishbone slave
    input wire pmp_wb_req_t wbReq,
    output logic [31:0] wbDatO,
    output logic wbAck,
    output logic wbErr,
    // Interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // Flag mapping
    // ----------------------------------------------------------------
    logic [15:0] errVec;
    logic [15:0] status_q;
    logic [15:0] irqStat_q;
    logic [15:0] irqMask_q;
    logic [15:0] wrData;
    logic reqNew;
    logic hitStatus;
    logic hitIrqStat;
    logic hitIrqMask;

    always_comb begin
        errVec = 16'h0000;
        errVec[BANK1_LSB +: SUBBANKS] = parityErr.bank1; // see RULE1 see RULE2
        errVec[BANK0_LSB +: SUBBANKS] = parityErr.bank0; // see RULE3
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign reqNew = wbReq.cyc && wbReq.stb && !wbAck && !wbErr;
    assign hitStatus = (wbReq.adr == PARITY_STATUS_ADDR); // see RULE5
    assign hitIrqStat = (wbReq.adr == IRQ_STATUS_ADDR);
    assign hitIrqMask = (wbReq.adr == IRQ_MASK_ADDR);
    assign wrData = {wbReq.sel[1] ? wbReq.dat[15:8] : 8'h00,
                     wbReq.sel[0] ? wbReq.dat[7:0] : 8'h00};

    // ----------------------------------------------------------------
    // Sticky parity flags, writes ignored
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= STATUS_RESET; // see RULE5
        end else begin
            status_q <= (status_q | errVec) & FLAG_MASK; // see RULE4 see RULE6
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status (write one to clear, set wins) and mask
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStat_q <= STATUS_RESET;
        end else begin
            if (reqNew && wbReq.we && hitIrqStat) begin
                irqStat_q <= ((irqStat_q & ~wrData) | errVec) & FLAG_MASK;
            end else begin
                irqStat_q <= (irqStat_q | errVec) & FLAG_MASK;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqMask_q <= MASK_RESET;
        end else if (reqNew && wbReq.we && hitIrqMask) begin
            irqMask_q <= (irqMask_q & ~{{8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}})
                         | (wrData & FLAG_MASK);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // ----------------------------------------------------------------
    // Answer: ack or err one cycle after the request, read data registered
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wbAck <= 1'b0;
            wbErr <= 1'b0;
            wbDatO <= 32'h0000_0000;
        end else begin
            wbAck <= reqNew && (hitStatus || hitIrqStat || hitIrqMask);
            wbErr <= reqNew && !(hitStatus || hitIrqStat || hitIrqMask);
            if (reqNew && !wbReq.we) begin
                if (hitStatus) begin
                    wbDatO <= {16'h0000, status_q}; // see RULE4
                end else if (hitIrqStat) begin
                    wbDatO <= {16'h0000, irqStat_q};
                end else if (hitIrqMask) begin
                    wbDatO <= {16'h0000, irqMask_q};
                end else begin
                    wbDatO <= 32'h0000_0000;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_b1sb5_sets: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE1
        parityErr.bank1[5] |=> status_q[13])
        else $error("bank1 subbank5 error did not set bit 13");
    a_b1_low_map: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE2
        |parityErr.bank1[4:0] |=> ((status_q[12:8] & $past(parityErr.bank1[4:0]))
        == $past(parityErr.bank1[4:0])))
        else $error("bank1 subbank flags misplaced");
    a_b0_map: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE3
        |parityErr.bank0 |=> ((status_q[5:0] & $past(parityErr.bank0))
        == $past(parityErr.bank0)))
        else $error("bank0 subbank flags misplaced");
    a_flag_ro: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE4
        (reqNew && wbReq.we && hitStatus) |=> (status_q & $past(status_q)) ==
        $past(status_q))
        else $error("status flag changed by write");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE6
        status_q[0] |=> status_q[0] [*8])
        else $error("flag dropped before reset");
    a_resvd_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE6
        (status_q & ~FLAG_MASK) == 16'h0000 ##1 (status_q & ~FLAG_MASK) == 16'h0000)
        else $error("reserved status bit set");

    // ----------------------------------------------------------------
    // Checks: bus answers and read data
    // ----------------------------------------------------------------
    a_status_read: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE5
        (reqNew && !wbReq.we && hitStatus) |=> wbAck &&
        wbDatO == {16'h0000, $past(status_q)})
        else $error("status read wrong");
    a_istat_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reqNew && !wbReq.we && hitIrqStat) |=> wbAck &&
        wbDatO == {16'h0000, $past(irqStat_q)})
        else $error("interrupt status read wrong");
    a_mask_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reqNew && !wbReq.we && hitIrqMask) |=> wbAck &&
        wbDatO == {16'h0000, $past(irqMask_q)})
        else $error("mask read wrong");
    a_resvd_read: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE6
        wbAck |-> (wbDatO & ~{16'h0000, FLAG_MASK}) == 32'h0000_0000)
        else $error("reserved bit read as one");
    // Read data stands until the next read is taken
    a_dat_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(reqNew && !wbReq.we) |=> $stable(wbDatO))
        else $error("read data changed without a read");
    a_ack_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reqNew && (hitStatus || hitIrqStat || hitIrqMask)) |=> wbAck && !wbErr)
        else $error("mapped request not acked");
    a_unmapped_err: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reqNew && !(hitStatus || hitIrqStat || hitIrqMask)) |=> wbErr && !wbAck)
        else $error("unmapped request not refused");
    a_ack_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
        wbAck |=> !wbAck)
        else $error("ack held two cycles");
    a_err_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
        wbErr |=> !wbErr)
        else $error("err held two cycles");
    a_no_dual_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(wbAck && wbErr))
        else $error("ack and err together");

    // ----------------------------------------------------------------
    // Checks: reset and interrupt
    // ----------------------------------------------------------------
    a_reset_zero: assert property (@(posedge core_clk) // see RULE5
        $rose(reset_n) |-> (status_q == STATUS_RESET) && (irqStat_q == STATUS_RESET)
        && (irqMask_q == MASK_RESET) && !irq && !wbAck && !wbErr)
        else $error("state not cleared by reset");
    a_irq_level: assert property (@(posedge core_clk) disable iff (!reset_n)
        (|(irqStat_q & irqMask_q)) |=> irq)
        else $error("irq not raised");
    a_irq_low: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(|(irqStat_q & irqMask_q)) |=> !irq)
        else $error("irq high with nothing pending");
    a_irq_rise_src: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(irq) |-> ($past(irqStat_q) & $past(irqMask_q)) != 16'h0000)
        else $error("irq rose with no unmasked status");
    // An event in the clearing cycle must survive the clear
    a_irq_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reqNew && wbReq.we && hitIrqStat) |=>
        (irqStat_q & $past(errVec)) == $past(errVec))
        else $error("event lost under clear");
    a_irq_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reqNew && wbReq.we && hitIrqStat && (wbReq.sel[1:0] == 2'b11)) |=>
        (irqStat_q & $past(wbReq.dat[15:0]) & ~$past(errVec)) == 16'h0000)
        else $error("interrupt status not cleared");
    a_mask_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reqNew && wbReq.we && hitIrqMask && (wbReq.sel[1:0] == 2'b11)) |=>
        irqMask_q == ($past(wbReq.dat[15:0]) & FLAG_MASK))
        else $error("mask write wrong");

    c_error_seen: cover property (@(posedge core_clk) disable iff (!reset_n)
        parityErr.bank1[5] ##1 status_q[13]);
    c_status_rd: cover property (@(posedge core_clk) disable iff (!reset_n)
        reqNew && !wbReq.we && hitStatus ##1 wbAck);
    c_irq_rise: cover property (@(posedge core_clk) disable iff (!reset_n)
        !irq ##1 irq);
    c_unmapped: cover property (@(posedge core_clk) disable iff (!reset_n)
        wbErr);
    c_set_wins: cover property (@(posedge core_clk) disable iff (!reset_n)
        reqNew && wbReq.we && hitIrqStat && (|errVec));

endmodule : pmp_parity_status

// *** dv/pmp_parity_status_test.sv ***
// Self-checking bench for the program-memory parity status block.
// Assumes the block answers every Wishbone cycle with either ack or err.
`timescale 1ns/1ns
module pmp_parity_status_test;
    import pmp_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    pmp_err_t parityErr = '0;
    pmp_wb_req_t wbReq = '0;
    logic [31:0] wbDatO;
    logic wbAck;
    logic wbErr;
    logic irq;
    logic [31:0] rdData;
    logic gotErr;
    int miscompares = 0;
    int total_checks = 0;
    int i;
    pmp_parity_status u_dut (.core_clk(core_clk), .reset_n(reset_n), .parityErr(parityErr),
        .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .wbErr(wbErr), .irq(irq));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Holds the request until the edge at which ack or err is seen high
    task automatic wb(input logic we, input logic [ADDR_W-1:0] adr, input logic [31:0] dat);
        @(posedge core_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: adr, dat: dat};
        do begin
            @(posedge core_clk);
        end while (wbAck !== 1'b1 && wbErr !== 1'b1);
        rdData = wbDatO;
        gotErr = wbErr;
        wbReq <= '0;
    endtask : wb
    task automatic pulse(input pmp_err_t e);
        @(posedge core_clk);
        parityErr <= e;
        @(posedge core_clk);
        parityErr <= '0;
    endtask : pulse
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        wb(1'b0, PARITY_STATUS_ADDR, 32'h0);
        check(rdData, 32'h0000_0000);
        wb(1'b0, IRQ_MASK_ADDR, 32'h0);
        check(rdData, 32'h0000_0000);
        check({31'h0, irq}, 32'h0);
    endtask : t_reset
    task automatic t_readonly;
        wb(1'b1, PARITY_STATUS_ADDR, 32'hFFFF_FFFF);
        wb(1'b0, PARITY_STATUS_ADDR, 32'h0);
        check(rdData, 32'h0000_0000);
    endtask : t_readonly
    task automatic t_flags;
        for (i = 0; i < SUBBANKS; i++) begin
            pulse('{bank1: 6'h00, bank0: 6'h01 << i});
            wb(1'b0, PARITY_STATUS_ADDR, 32'h0);
            check(rdData, (32'h2 << i) - 32'h1);
        end
        for (i = 0; i < SUBBANKS; i++) begin
            pulse('{bank1: 6'h01 << i, bank0: 6'h00});
            wb(1'b0, PARITY_STATUS_ADDR, 32'h0);
            check(rdData, 32'h3F + (32'h200 << i) - 32'h100);
        end
    endtask : t_flags
    task automatic t_irq;
        check({31'h0, irq}, 32'h0);
        wb(1'b1, IRQ_MASK_ADDR, 32'h0000_2000);
        @(negedge core_clk);
        check({31'h0, irq}, 32'h1);
        wb(1'b0, IRQ_MASK_ADDR, 32'h0);
        check(rdData, 32'h0000_2000);
        wb(1'b0, IRQ_STATUS_ADDR, 32'h0);
        check(rdData, 32'h0000_3F3F);
        wb(1'b1, IRQ_STATUS_ADDR, 32'h0000_3F3F);
        @(negedge core_clk);
        check({31'h0, irq}, 32'h0);
        wb(1'b0, IRQ_STATUS_ADDR, 32'h0);
        check(rdData, 32'h0000_0000);
        wb(1'b0, PARITY_STATUS_ADDR, 32'h0);
        check(rdData, 32'h0000_3F3F);
        wb(1'b0, PARITY_STATUS_ADDR + 18'h20, 32'h0);
        check({31'h0, gotErr}, 32'h1);
    endtask : t_irq
    // Clear and a new event in the same cycle: the event must survive
    task automatic t_set_wins;
        @(posedge core_clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, sel: 4'h3, adr: IRQ_STATUS_ADDR,
                   dat: 32'h0000_0001};
        parityErr <= '{bank1: 6'h00, bank0: 6'h01};
        @(posedge core_clk);
        parityErr <= '0;
        while (wbAck !== 1'b1 && wbErr !== 1'b1) begin
            @(posedge core_clk);
        end
        wbReq <= '0;
        wb(1'b0, IRQ_STATUS_ADDR, 32'h0);
        check(rdData, 32'h0000_0001);
    endtask : t_set_wins
    task automatic t_rereset;
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        wb(1'b0, PARITY_STATUS_ADDR, 32'h0);
        check(rdData, 32'h0000_0000);
        wb(1'b0, IRQ_STATUS_ADDR, 32'h0);
        check(rdData, 32'h0000_0000);
        wb(1'b0, IRQ_MASK_ADDR, 32'h0);
        check(rdData, 32'h0000_0000);
        check({31'h0, irq}, 32'h0);
    endtask : t_rereset
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset();
        t_readonly();
        t_flags();
        t_irq();
        t_set_wins();
        t_rereset();
        end_of_test();
    end
endmodule : pmp_parity_status_test
